// file: rtl/supply_line_manchester_config_port.sv
// Manchester command receiver, reply sender and configuration memory of the sensor.
// How it works
// R1 - Word 0x15 bit 18 picks turn step: 0 gives 180 degrees, 1 gives 45.
// R2 - Eight-bit sleep interval field, default 48, counts roughly 2 ms steps.
// R3 - Ten-bit velocity window field, default 157, is held and exported.
// R4 - Eleven-bit awake motion limit at word 0x16 bits 22..12, default 26.
// R5 - Eleven-bit sleep motion limit field, default 682, is held and exported.
// R6 - Rising mid-cell edge is a 0, falling mid-cell edge is a 1.
// R7 - Address and data travel most significant bit first.
// R8 - Two strap pins give the die address, four dies addressable.
// R9 - Lock bit at word 0x19 bit 18 makes the port ignore the line.
// R10 - Unlocked port listens always but acts only after the open code.
// R11 - Open code enters communication mode; output pin carries replies.
// R12 - Close code returns the output pin to angle data.
// R13 - Entering communication mode abandons any angle frame in flight.
// R14 - Commands arrive on the supply line, read replies leave on output pin.
// R15 - The port never starts an exchange by itself.
// R16 - Only write, read, open and close commands are recognised.
// R17 - Both EEPROM and volatile memory are readable and writable.
// R18 - Controller sends two high-voltage strobes after each EEPROM write.
// R19 - Two detected strobes commit the pending EEPROM write.
// R20 - Controller keeps 4 to 50 kbps; receiver follows each frame's rate.
// R21 - Incomplete or malformed frames change neither memory nor mode.
`timescale 1ns/1ps
`default_nettype none
module supply_line_manchester_config_port #(
  parameter int SLEEP_STEP_CYCLES = mancfg_pkg::SLEEP_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic supplyData,
  input wire logic progStrobe,
  input wire logic dieAddrBit0,
  input wire logic dieAddrBit1,
  input wire logic angleLevel,
  input wire logic lowPowerState,
  output logic nibbleOut,
  output logic commMode,
  output logic angleAbort,
  output logic sleepWake,
  output mancfg_pkg::cfg_t cfg
);
  initial begin
    if (SLEEP_STEP_CYCLES < 1 || SLEEP_STEP_CYCLES > 65535) begin
      $error("SLEEP_STEP_CYCLES out of range");
    end
  end

  typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_BITS} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} tx_state_t;

  // Reset release through two flops; assertion stays asynchronous.
  logic rstMeta, rstSync;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  wire logic rstN = rstSync;

  // Pin synchronisers; only the second stage is read by logic.
  logic [3:0] pinMeta, pinSync;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pinMeta <= 4'h1;
      pinSync <= 4'h1;
    end else begin
      pinMeta <= {dieAddrBit1, dieAddrBit0, progStrobe, supplyData};
      pinSync <= pinMeta;
    end
  end

  // Straps are sampled until the synchroniser holds real pin levels, then kept.
  logic [1:0] dieAddr;
  logic [1:0] strapAge;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      dieAddr <= 2'h0;
      strapAge <= 2'h0;
    end else if (strapAge != 2'h3) begin
      dieAddr <= pinSync[3:2]; // R8
      strapAge <= strapAge + 2'h1;
    end
  end

  // Edge detection on the synchronised supply line and strobe.
  logic lineD, strobeD;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      lineD <= 1'b1;
      strobeD <= 1'b0;
    end else begin
      lineD <= pinSync[0];
      strobeD <= pinSync[1];
    end
  end
  wire logic riseEdge = pinSync[0] & ~lineD;
  wire logic fallEdge = ~pinSync[0] & lineD;
  wire logic strobeRise = pinSync[1] & ~strobeD;

  // Memories and lock bit.
  logic [31:0] eeMem [32];
  logic [31:0] volMem [32];
  wire logic locked = eeMem[mancfg_pkg::LOCK_WORD][mancfg_pkg::LOCK_BIT]; // R9

  // Receiver: the sync cell's low half sets the rate for the whole frame.
  rx_state_t rxState;
  logic [mancfg_pkg::CNT_W-1:0] rxCnt, halfCyc;
  logic [41:0] rxShift;
  logic [5:0] rxBits;
  logic frameEnd;
  localparam int CNT_W = mancfg_pkg::CNT_W;
  wire logic [mancfg_pkg::CNT_W-1:0] midGate = halfCyc + (halfCyc >> 1);
  wire logic [mancfg_pkg::CNT_W-1:0] endGate = CNT_W'(3 * 32'(halfCyc));
  wire logic rateOk = rxCnt >= CNT_W'(mancfg_pkg::HALF_MIN_CYC); // R20
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rxState <= RX_IDLE;
      rxCnt <= '0;
      halfCyc <= '0;
      rxShift <= '0;
      rxBits <= '0;
      frameEnd <= 1'b0;
    end else begin
      frameEnd <= 1'b0;
      unique case (rxState)
        RX_IDLE: begin
          rxCnt <= CNT_W'(1); // The falling edge cycle is the first low cycle.
          if (fallEdge && !locked) begin // R9
            rxState <= RX_SYNC;
          end
        end
        RX_SYNC: begin
          if (locked) begin
            rxState <= RX_IDLE;
          end else if (riseEdge) begin
            halfCyc <= rxCnt;
            rxCnt <= '0;
            rxBits <= '0;
            rxState <= rateOk ? RX_BITS : RX_IDLE; // R21
          end else if (rxCnt == CNT_W'(mancfg_pkg::HALF_MAX_CYC)) begin
            rxState <= RX_IDLE; // R21
          end else begin
            rxCnt <= rxCnt + 1'b1;
          end
        end
        RX_BITS: begin
          if ((riseEdge || fallEdge) && rxCnt >= midGate) begin
            rxShift <= {rxShift[40:0], fallEdge}; // R6 R7
            rxBits <= (rxBits == 6'h3f) ? rxBits : rxBits + 1'b1;
            rxCnt <= '0;
          end else if (rxCnt >= endGate) begin
            rxState <= RX_IDLE;
            frameEnd <= ~locked;
          end else begin
            rxCnt <= rxCnt + 1'b1;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Frame decode; long frames carry a data word behind the address.
  wire logic isLong = rxBits == 6'(mancfg_pkg::WRITE_BITS);
  wire logic isShort = rxBits == 6'(mancfg_pkg::SHORT_BITS);
  mancfg_pkg::frame_t frm;
  assign frm = isLong ? rxShift : {rxShift[9:0], 32'h0};
  wire logic lenOk = (isLong && frm.cmd == mancfg_pkg::CMD_WRITE)
      || (isShort && frm.cmd != mancfg_pkg::CMD_WRITE); // R16 R21
  wire logic accept = frameEnd && lenOk && frm.die == dieAddr; // R8
  wire logic doOpen = accept && frm.cmd == mancfg_pkg::CMD_OPEN;
  wire logic doClose = accept && frm.cmd == mancfg_pkg::CMD_CLOSE;
  wire logic doRead = accept && commMode && frm.cmd == mancfg_pkg::CMD_READ; // R10 R15
  wire logic doWrite = accept && commMode && frm.cmd == mancfg_pkg::CMD_WRITE; // R10
  wire logic volSel = frm.addr[mancfg_pkg::VOL_SEL_BIT];
  wire logic [4:0] wordSel = frm.addr[4:0];

  // Communication mode and the one-cycle abort to the angle framer.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      commMode <= 1'b0;
      angleAbort <= 1'b0;
    end else begin
      angleAbort <= doOpen && !commMode; // R13
      if (locked) begin
        commMode <= 1'b0; // R9
      end else if (doOpen) begin
        commMode <= 1'b1; // R11
      end else if (doClose) begin
        commMode <= 1'b0; // R12
      end
    end
  end

  // EEPROM writes wait in a holding word until two strobes commit them.
  logic pendValid, strobeSeen;
  logic [4:0] pendAddr;
  logic [31:0] pendData;
  function automatic logic [31:0] eeDefault(input int idx);
    if (idx == int'(mancfg_pkg::TURN_WORD)) begin
      return mancfg_pkg::WORD15_RST;
    end
    if (idx == int'(mancfg_pkg::AWAKE_WORD)) begin
      return mancfg_pkg::WORD16_RST;
    end
    return 32'h0;
  endfunction
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pendValid <= 1'b0;
      strobeSeen <= 1'b0;
      pendAddr <= '0;
      pendData <= '0;
      for (int i = 0; i < 32; i++) begin
        eeMem[i] <= eeDefault(i);
        volMem[i] <= 32'h0;
      end
    end else begin
      if (doWrite && volSel) begin
        volMem[wordSel] <= frm.data; // R17
      end
      if (doWrite && !volSel) begin
        pendValid <= 1'b1; // R17
        strobeSeen <= 1'b0;
        pendAddr <= wordSel;
        pendData <= frm.data;
      end else if (pendValid && strobeRise) begin
        if (strobeSeen) begin
          eeMem[pendAddr] <= pendData; // R19
          pendValid <= 1'b0;
          strobeSeen <= 1'b0;
        end else begin
          strobeSeen <= 1'b1; // R18 R19
        end
      end
    end
  end

  // Reply sender: waits 5/8 bit, then a 0 sync bit and 32 data bits.
  tx_state_t txState;
  logic [CNT_W-1:0] txCnt;
  logic [32:0] txShift;
  logic [5:0] txLeft;
  logic txPhase;
  wire logic [CNT_W-1:0] txDelay = halfCyc + (halfCyc >> 2);
  wire logic [31:0] readWord = volSel ? volMem[wordSel] : eeMem[wordSel];
  wire logic halfDone = txCnt >= halfCyc - 1'b1;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      txState <= TX_IDLE;
      txCnt <= '0;
      txShift <= '0;
      txLeft <= '0;
      txPhase <= 1'b0;
    end else begin
      unique case (txState)
        TX_IDLE: begin
          txCnt <= '0;
          txPhase <= 1'b0;
          if (doRead) begin
            txShift <= {1'b0, readWord}; // R7
            txLeft <= 6'h21;
            txState <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          txCnt <= txCnt + 1'b1;
          if (txCnt >= txDelay) begin
            txCnt <= '0;
            txState <= TX_SEND;
          end
        end
        TX_SEND: begin
          txCnt <= halfDone ? '0 : txCnt + 1'b1;
          if (halfDone) begin
            txPhase <= ~txPhase;
            if (txPhase) begin
              txShift <= {txShift[31:0], 1'b0};
              txLeft <= txLeft - 1'b1;
              if (txLeft == 6'h01) begin
                txState <= TX_IDLE;
              end
            end
          end
          if (!commMode) begin
            txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end
  // Low first half then high encodes 0: level is bit in first half, inverse after.
  wire logic txLevel = (txState == TX_SEND) ? (txShift[32] ^ txPhase) : 1'b1; // R6

  // Output pin is registered so the mode switch never glitches the line.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      nibbleOut <= 1'b1;
    end else begin
      nibbleOut <= commMode ? txLevel : angleLevel; // R11 R12 R14
    end
  end

  // Configuration fields taken straight from the stored EEPROM words.
  wire logic [31:0] word15 = eeMem[mancfg_pkg::TURN_WORD];
  wire logic [31:0] word16 = eeMem[mancfg_pkg::AWAKE_WORD];
  assign cfg.turnStep45 = word15[mancfg_pkg::TURN_BIT]; // R1
  assign cfg.sleepIntervalSetting = word15[mancfg_pkg::SLEEP_LSB +: 8]; // R2
  assign cfg.velocityWindowSetting = word15[mancfg_pkg::VEL_LSB +: 10]; // R3
  assign cfg.awakeMotionLimitSetting = word16[mancfg_pkg::AWAKE_LSB +: 11]; // R4
  assign cfg.sleepMotionLimitSetting = word16[mancfg_pkg::SLEEP_LIM_LSB +: 11]; // R5

  // Sleep timer: a 2 ms step enable and a step count; a zero setting acts as one step.
  logic [15:0] stepCnt;
  logic [7:0] sleepSteps;
  wire logic stepTick = stepCnt == 16'(SLEEP_STEP_CYCLES - 1);
  wire logic [7:0] sleepLast = (cfg.sleepIntervalSetting == 8'h0) ? 8'h0
      : cfg.sleepIntervalSetting - 1'b1;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      stepCnt <= '0;
      sleepSteps <= '0;
      sleepWake <= 1'b0;
    end else begin
      sleepWake <= 1'b0;
      if (!lowPowerState) begin
        stepCnt <= '0;
        sleepSteps <= '0;
      end else if (stepTick) begin
        stepCnt <= '0;
        sleepSteps <= (sleepSteps >= sleepLast) ? 8'h0 : sleepSteps + 1'b1;
        sleepWake <= sleepSteps >= sleepLast; // R2
      end else begin
        stepCnt <= stepCnt + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/mancfg_pkg.sv
// Constants and carrier types for the supply-line Manchester configuration port.
package mancfg_pkg;
  // Clock and link timing.
  localparam int CLK_HZ = 20_000_000;
  localparam int MIN_RATE_BPS = 4_000;
  localparam int MAX_RATE_BPS = 50_000;
  localparam int RATE_TOL_PCT = 11;
  // Shortest and longest legal half bit cell in clock cycles, with bit-time tolerance.
  localparam int HALF_MIN_CYC = CLK_HZ / (2 * MAX_RATE_BPS) * (100 - RATE_TOL_PCT) / 100;
  localparam int HALF_MAX_CYC = CLK_HZ / (2 * MIN_RATE_BPS) * (100 + RATE_TOL_PCT) / 100;
  localparam int CNT_W = 14;
  // Sleep interval step.
  localparam int SLEEP_STEP_US = 2000;
  localparam int SLEEP_STEP_CYC = CLK_HZ / 1_000_000 * SLEEP_STEP_US;
  // Frame layout: die address, command, memory address, optional data word.
  localparam int SHORT_BITS = 10;
  localparam int WRITE_BITS = 42;
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_OPEN = 2'h2;
  localparam logic [1:0] CMD_CLOSE = 2'h3;
  // Memory map; address bit 5 selects volatile memory.
  localparam int VOL_SEL_BIT = 5;
  localparam logic [4:0] TURN_WORD = 5'h15;
  localparam int TURN_BIT = 18;
  localparam int SLEEP_LSB = 10;
  localparam int VEL_LSB = 0;
  localparam logic [4:0] AWAKE_WORD = 5'h16;
  localparam int AWAKE_LSB = 12;
  localparam int SLEEP_LIM_LSB = 0;
  localparam logic [4:0] LOCK_WORD = 5'h19;
  localparam int LOCK_BIT = 18;
  // Field defaults.
  localparam logic [0:0] TURN_RST = 1'h0;
  localparam logic [7:0] SLEEP_RST = 8'h30;
  localparam logic [9:0] VEL_RST = 10'h09d;
  localparam logic [10:0] AWAKE_RST = 11'h01a;
  localparam logic [10:0] SLEEP_LIM_RST = 11'h2aa;
  localparam logic [31:0] WORD15_RST = (32'(TURN_RST) << TURN_BIT)
      | (32'(SLEEP_RST) << SLEEP_LSB) | (32'(VEL_RST) << VEL_LSB);
  localparam logic [31:0] WORD16_RST = (32'(AWAKE_RST) << AWAKE_LSB)
      | (32'(SLEEP_LIM_RST) << SLEEP_LIM_LSB);

  // Configuration fields handed to the low-power and turns logic.
  typedef struct packed {
    logic turnStep45;
    logic [7:0] sleepIntervalSetting;
    logic [9:0] velocityWindowSetting;
    logic [10:0] awakeMotionLimitSetting;
    logic [10:0] sleepMotionLimitSetting;
  } cfg_t;

  // One decoded command frame.
  typedef struct packed {
    logic [1:0] die;
    logic [1:0] cmd;
    logic [5:0] addr;
    logic [31:0] data;
  } frame_t;
endpackage

// file: tb/mancfg_sva.sv
// Checker for the Manchester configuration port outputs.
`timescale 1ns/1ps
`default_nettype none
module mancfg_sva #(
  parameter int SLEEP_STEP_CYCLES = mancfg_pkg::SLEEP_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic supplyData,
  input wire logic progStrobe,
  input wire logic angleLevel,
  input wire logic lowPowerState,
  input wire logic nibbleOut,
  input wire logic commMode,
  input wire logic angleAbort,
  input wire logic sleepWake,
  input wire mancfg_pkg::cfg_t cfg
);
  logic [23:0] gap;
  logic [23:0] period;
  logic [7:0] steps;
  logic [9:0] hiRun;
  logic [2:0] upCnt;
  logic [11:0] loRun;
  logic syncLow;
  logic gapClean;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // A zero sleep setting behaves as one step.
  assign steps = (cfg.sleepIntervalSetting == 8'h00) ? 8'h01 : cfg.sleepIntervalSetting;
  assign period = 24'(steps) * 24'(SLEEP_STEP_CYCLES);
  // Wake gaps only count while power state and setting stay put, since a power state change restarts them and a setting change alters them.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 24'h000000;
      gapClean <= 1'b0;
      hiRun <= 10'h000;
      upCnt <= 3'h0;
      loRun <= 12'h000;
      syncLow <= 1'b0;
    end else begin
      gap <= sleepWake ? 24'h000001 : gap + 24'h000001;
      gapClean <= sleepWake ? lowPowerState : gapClean && lowPowerState && $stable(cfg);
      hiRun <= !nibbleOut ? 10'h000 : ((hiRun == 10'h3ff) ? hiRun : hiRun + 10'h001);
      upCnt <= (upCnt == 3'h7) ? upCnt : upCnt + 3'h1;
      // Length of the current low run, and whether it is a reply sync half.
      loRun <= nibbleOut ? 12'h000 : ((loRun == 12'hfff) ? loRun : loRun + 12'h001);
      syncLow <= (commMode && (hiRun == 10'h3ff) && !nibbleOut) || (syncLow && !nibbleOut);
    end
  end
  AST_ABORT_ONE_CYCLE: assert property (angleAbort |=> !angleAbort)
    else $error("abort pulse longer than one cycle");
  AST_ENTRY_ABORTS: assert property ($rose(commMode) |->
    (angleAbort || $past(angleAbort)) or ##1 angleAbort) else $error("entry without abort");
  AST_ABORT_FRESH: assert property (angleAbort |-> !$past(commMode, 2))
    else $error("abort while already in communication mode");
  AST_ANGLE_PASS: assert property ((upCnt == 3'h7) && !commMode && !$past(commMode)
    && !$past(commMode, 2) |-> nibbleOut == $past(angleLevel)
    || nibbleOut == $past(angleLevel, 2)) else $error("angle level not passed through");
  AST_REPLY_SYNC: assert property (commMode && (hiRun == 10'h3ff) && $fell(nibbleOut)
    |-> ##170 !nibbleOut) else $error("reply start bit malformed");
  AST_REPLY_SYNC_END: assert property (syncLow |-> loRun <= 12'haf0)
    else $error("reply sync half too long");
  AST_MODE_AT_REST: assert property ($changed(commMode)
    |-> $past(supplyData, 2) && $past(supplyData, 6)) else $error("mode changed mid frame");
  AST_WAKE_NEEDS_LP: assert property (sleepWake
    |-> $past(lowPowerState) || $past(lowPowerState, 2)) else $error("wake while awake");
  AST_WAKE_PERIOD: assert property (sleepWake && gapClean |-> gap == period)
    else $error("sleep interval length wrong");
  AST_CFG_ON_COMMIT: assert property (!$stable(cfg)
    |-> $past(progStrobe, 2) || $past(progStrobe, 4)) else $error("cfg changed unstrobed");
  cover property ($rose(commMode));
  cover property (sleepWake && gapClean);
  cover property (!$stable(cfg));
endmodule
bind supply_line_manchester_config_port mancfg_sva #(.SLEEP_STEP_CYCLES(SLEEP_STEP_CYCLES)) u_sva (
  .mclk(mclk), .rst_b(rst_b), .supplyData(supplyData), .progStrobe(progStrobe),
  .angleLevel(angleLevel), .lowPowerState(lowPowerState), .nibbleOut(nibbleOut),
  .commMode(commMode), .angleAbort(angleAbort), .sleepWake(sleepWake), .cfg(cfg));
`default_nettype wire

// file: tb/mancfg_ctrl.sv
// Programming controller model that drives the supply line and the strobe detector.
`timescale 1ns/1ps
`default_nettype none
module mancfg_ctrl #(
  parameter int H = 200
) (
  input wire logic mclk,
  output logic supplyData,
  output logic progStrobe
);
  // The supply line rests high between frames.
  initial begin
    supplyData = 1'b1;
    progStrobe = 1'b0;
  end
  // Levels change just after a falling edge and hold for n clocks.
  task automatic hold(input logic v, input int n);
    supplyData = v;
    repeat (n) @(negedge mclk);
  endtask
  // H of 200 clocks at 20 MHz is a 50 kbps frame; a zero sync bit sets the rate.
  task automatic send(input logic [41:0] f, input int n);
    hold(1'b0, H);
    hold(1'b1, H);
    for (int i = 41; i > 41 - n; i--) begin
      hold(f[i], H);
      hold(!f[i], H);
    end
    hold(1'b1, 5 * H);
  endtask
  // Two programming strobes follow every EEPROM write.
  task automatic strobes();
    repeat (2) begin
      progStrobe = 1'b1;
      repeat (20) @(negedge mclk);
      progStrobe = 1'b0;
      repeat (20) @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/supply_line_manchester_config_port_bench.sv
// Self-checking bench for the supply-line Manchester configuration port.
`timescale 1ns/1ps
`default_nettype none
module supply_line_manchester_config_port_bench;
  localparam int H = 200;
  localparam int STEP = 10;
  localparam logic [40:0] DEF = {1'h0, 8'h30, 10'h09d, 11'h01a, 11'h2aa};
  logic mclk, rst_b, supplyData, progStrobe, dieAddrBit0, dieAddrBit1, angleLevel;
  logic lowPowerState, nibbleOut, commMode, angleAbort, sleepWake, sawAbort;
  mancfg_pkg::cfg_t cfg;
  int failures, tests_run;
  logic [31:0] expq[$];
  logic [31:0] w;
  logic [1:0] die;
  supply_line_manchester_config_port #(.SLEEP_STEP_CYCLES(STEP)) u_supply_line_manchester_config_port (
    .mclk(mclk), .rst_b(rst_b), .supplyData(supplyData), .progStrobe(progStrobe),
    .dieAddrBit0(dieAddrBit0), .dieAddrBit1(dieAddrBit1), .angleLevel(angleLevel),
    .lowPowerState(lowPowerState), .nibbleOut(nibbleOut), .commMode(commMode),
    .angleAbort(angleAbort), .sleepWake(sleepWake), .cfg(cfg));
  mancfg_ctrl #(.H(H)) u_mancfg_ctrl (.mclk(mclk), .supplyData(supplyData), .progStrobe(progStrobe));
  // Free-running 20 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Random angle traffic keeps the pass-through path busy; abort pulses are latched.
  always @(negedge mclk) begin
    angleLevel <= 1'($urandom_range(1, 0));
    if (rst_b !== 1'b1) begin
      sawAbort <= 1'b0;
    end else if (angleAbort === 1'b1) begin
      sawAbort <= 1'b1;
    end
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d compared, %0d failed", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Short frames carry die, command and address; writes add the data word.
  task automatic cmd(input logic [1:0] d, input logic [1:0] c, input logic [5:0] a,
                     input logic [31:0] v);
    u_mancfg_ctrl.send({d, c, a, v}, (c == mancfg_pkg::CMD_WRITE) ? 42 : 10);
  endtask
  // Measures the gap between two wake pulses; the wait is bounded.
  task automatic wakeGap(input int expGap);
    int n;
    lowPowerState = 1'b1;
    repeat (2) begin
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (sleepWake !== 1'b1 && n < 6000);
    end
    lowPowerState = 1'b0;
    check(48'(n), 48'(expGap));
  endtask
  // Decode each read reply and compare it with the oldest note.
  initial begin : replyMon
    logic [31:0] got;
    forever begin
      @(negedge nibbleOut);
      repeat (H / 2) @(negedge mclk);
      if (commMode === 1'b1 && nibbleOut === 1'b0) begin
        repeat (2 * H) @(negedge mclk);
        for (int i = 31; i >= 0; i--) begin
          got[i] = nibbleOut;
          repeat (2 * H) @(negedge mclk);
        end
        check(48'(got), 48'((expq.size() > 0) ? expq.pop_front() : ~got));
      end
    end
  end
  // A hang is cut short beyond the expected run of at most about 89000 clocks.
  initial begin
    #(95_000 * 50);
    failures++;
    $display("[ERR] %0t ns: run did not finish", $time);
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h6458));
    rst_b = 1'b0;
    lowPowerState = 1'b0;
    die = 2'($urandom_range(3, 0));
    {dieAddrBit1, dieAddrBit0} = die;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    repeat (6) @(negedge mclk);
    check(48'(cfg), 48'(DEF));
    wakeGap(48 * STEP);
    $display("test defaults done");
    cmd(~die, mancfg_pkg::CMD_OPEN, 6'h00, 32'h0);
    check(48'(commMode), 48'h0);
    cmd(die, mancfg_pkg::CMD_OPEN, 6'h00, 32'h0);
    check(48'(commMode), 48'h1);
    check(48'(sawAbort), 48'h1);
    check(48'(nibbleOut), 48'h1);
    $display("test open done");
    w = $urandom;
    cmd(die, mancfg_pkg::CMD_WRITE, 6'h15, w);
    check(48'(cfg), 48'(DEF));
    u_mancfg_ctrl.strobes();
    repeat (8) @(negedge mclk);
    check(48'(cfg), 48'({w[18], w[17:10], w[9:0], 11'h01a, 11'h2aa}));
    wakeGap(((w[17:10] == 8'h00) ? 1 : int'(w[17:10])) * STEP);
    $display("test write done");
    expq.push_back({9'h000, 11'h01a, 1'h0, 11'h2aa});
    cmd(die, mancfg_pkg::CMD_READ, 6'h16, 32'h0);
    for (int i = 0; i < 20000 && expq.size() > 0; i++) @(negedge mclk);
    check(48'(expq.size()), 48'h0);
    repeat (2 * H) @(negedge mclk);
    $display("test read done");
    cmd(die, mancfg_pkg::CMD_CLOSE, 6'h00, 32'h0);
    check(48'(commMode), 48'h0);
    $display("test close done");
    cmd(die, mancfg_pkg::CMD_OPEN, 6'h00, 32'h0);
    cmd(die, mancfg_pkg::CMD_WRITE, 6'h19, 32'h00040000);
    u_mancfg_ctrl.strobes();
    repeat (8) @(negedge mclk);
    check(48'(commMode), 48'h0);
    cmd(die, mancfg_pkg::CMD_OPEN, 6'h00, 32'h0);
    check(48'(commMode), 48'h0);
    $display("test lock done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
